/* hdl/sbml_loader.sv */
/*
  Serial boot mode loader: makes the mode clock, shifts in the boot
  word, decodes it and offers it over an AXI4-Lite register slave.
  Assumes one 50 MHz clock, a synchronous active-low reset, and a
  serial source that changes data while the mode clock is low.
*/
// What this block does
// - Take exactly 256 serial bits, one per mode-clock period, in order.
// - Mode clock low 128 clocks after power good, then period 256.
// - Capture a bit on each rising mode-clock edge, starting the first.
// - Only the leading defined bits mean anything; the rest are reserved.
// - Order bit 1 picks sub-block order, 0 sequential order.
// - Dirty-shared bit at 0 enables dirty shared mode.
// - Cache-absent bit at 0 means a secondary cache is present.
// - Line size code 11 selects 32-word lines.
// - Line size picks 4, 8, 16 or 32 words.
// - Four-bit pattern field sets write data rate; 0000 is DD.
// - Ratio code 010 runs the system interface at clock over 4.
// - Timer-disconnect bit at 0 connects the timer interrupt.
// - Secondary cache timing comes from the seven loaded timing fields.
// - Power-down clock divisor comes from its four-bit field.
// - Two four-bit slew strengths; pull-down msb has opposite polarity.
// - Slew control off when enable is 0, or in cold reset while the slew cold-reset enable bit is 0.
// - PLLs enabled when the PLL-disable bit is 0.
// - Float bit 1 floats interface outputs during warm or cold reset.
`include "sbml_params.svh"
`default_nettype none

module sbml_loader
  import sbml_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        power_good,
  input  wire logic        config_serial_in,
  input  wire logic        cold_reset_in,
  input  wire logic        warm_reset_in,
  output logic             config_shift_clock,
  output logic             config_valid,
  output sbml_fields_type  config_fields,
  output logic             sysif_float,
  output logic             slew_ctl_active,
  output logic             sysif_clk_en,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ==========================================================
  // Declarations
  sbml_state_type state;
  logic [6:0]     half_cnt;
  logic [8:0]     bit_cnt;
  logic [255:0]   hold;
  logic           load_done;
  logic           reload_req;
  logic           reserved_dirty;
  logic           order_illegal;
  logic [3:0]     div_cnt;
  logic [3:0]     div_ratio;
  logic           aw_full;
  logic           w_full;
  logic [7:0]     aw_addr;
  logic [31:0]    w_data;
  logic [3:0]     w_strb;
  logic [7:0]     gap_cnt;

  sbml_cfg_if cfg ();

  assign cfg.raw = hold[`SBML_DEFINED_BITS-1:0];

  sbml_decode u_decode (
    .cfg (cfg.decoder)
  );

  assign load_done = (state == SBML_DONE);

  // ==========================================================
  // Sequencer and mode clock
  // The mode clock keeps toggling after the load, as some boards
  // count it to time their own cold reset release.
  always_ff @(posedge aclk) begin
    if (!aresetn || !power_good || reload_req) begin
      state              <= SBML_IDLE;
      half_cnt           <= 7'h00;
      bit_cnt            <= 9'h000;
      config_shift_clock <= 1'b1;
    end else begin
      case (state)
        SBML_IDLE: begin
          state    <= SBML_LEAD;
          half_cnt <= 7'h00;
        end
        SBML_LEAD: begin
          if (half_cnt == `SBML_HALF_PERIOD) begin
            config_shift_clock <= 1'b0;
            half_cnt           <= 7'h00;
            state              <= SBML_RUN;
          end else begin
            half_cnt <= half_cnt + 7'h01;
          end
        end
        SBML_RUN, SBML_DONE: begin
          if (half_cnt == `SBML_HALF_PERIOD) begin
            config_shift_clock <= !config_shift_clock;
            half_cnt           <= 7'h00;
            if (!config_shift_clock && state == SBML_RUN) begin
              bit_cnt <= bit_cnt + 9'h001;
              if (bit_cnt == `SBML_TOTAL_BITS - 9'h001) begin
                state <= SBML_DONE;
              end
            end
          end else begin
            half_cnt <= half_cnt + 7'h01;
          end
        end
        default: begin
          state <= SBML_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Holding register, filled in arrival order
  // Not cleared on reload, so the old word stays readable until
  // each bit is overwritten.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold <= '0;
    end else if (state == SBML_RUN && !config_shift_clock
                 && half_cnt == `SBML_HALF_PERIOD) begin
      hold[bit_cnt[7:0]] <= config_serial_in;
    end
  end

  // ==========================================================
  // Checks on the loaded word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reserved_dirty <= 1'b0;
      order_illegal  <= 1'b0;
    end else begin
      reserved_dirty <= load_done
                        && (|hold[255:`SBML_DEFINED_BITS]);
      order_illegal  <= load_done && !cfg.fields.second_cache_present
                        && !cfg.fields.sub_block_order;
    end
  end

  // ==========================================================
  // Decoded outputs, held at zero until a full word is in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_valid  <= 1'b0;
      config_fields <= '0;
    end else begin
      config_valid  <= load_done;
      config_fields <= load_done ? cfg.fields : '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sysif_float     <= 1'b0;
      slew_ctl_active <= 1'b0;
    end else begin
      sysif_float     <= load_done && cfg.fields.reset_output_float
                         && (cold_reset_in || warm_reset_in);
      slew_ctl_active <= load_done && cfg.fields.slew_ctl_enable
                         && (!cold_reset_in
                             || cfg.fields.slew_ctl_cold_reset_enable);
    end
  end

  // ==========================================================
  // System interface clock enable
  assign div_ratio = load_done ? cfg.fields.sysif_divide
                               : `SBML_DIV_DEFAULT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt      <= 4'h0;
      sysif_clk_en <= 1'b0;
    end else if (div_cnt >= div_ratio - 4'h1) begin
      div_cnt      <= 4'h0;
      sysif_clk_en <= 1'b1;
    end else begin
      div_cnt      <= div_cnt + 4'h1;
      sysif_clk_en <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_full       <= 1'b0;
      aw_addr       <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_full       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
    end else if (aw_full && w_full && !s_axi_bvalid) begin
      aw_full <= 1'b0;
    end else begin
      s_axi_awready <= !aw_full && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_full       <= 1'b0;
      w_data       <= `SBML_DATA_RESET;
      w_strb       <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_full       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else if (aw_full && w_full && !s_axi_bvalid) begin
      w_full <= 1'b0;
    end else begin
      s_axi_wready <= !w_full && !s_axi_bvalid;
    end
  end

  // Only the control word takes writes; status and raw words refuse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SBML_RESP_OKAY;
      reload_req   <= 1'b0;
    end else begin
      reload_req <= 1'b0;
      if (aw_full && w_full && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `SBML_ADDR_CTRL) begin
          s_axi_bresp <= `SBML_RESP_OKAY;
          reload_req  <= w_strb[0] && w_data[`SBML_CTRL_RELOAD];
        end else begin
          s_axi_bresp <= `SBML_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `SBML_DATA_RESET;
      s_axi_rresp   <= `SBML_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `SBML_RESP_OKAY;
      case (s_axi_araddr)
        `SBML_ADDR_CTRL:    s_axi_rdata <= `SBML_DATA_RESET;
        `SBML_ADDR_STATUS:  s_axi_rdata <= {15'h0000, bit_cnt, 4'h0,
                                            order_illegal, reserved_dirty,
                                            state == SBML_RUN, load_done};
        `SBML_ADDR_RAW_LO:  s_axi_rdata <= hold[31:0];
        `SBML_ADDR_RAW_HI:  s_axi_rdata <= hold[63:32];
        `SBML_ADDR_RAW_TOP: s_axi_rdata <= {31'h0000_0000, hold[64]};
        default: begin
          s_axi_rdata <= `SBML_DATA_RESET;
          s_axi_rresp <= `SBML_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // ==========================================================
  // Checks
  always_ff @(posedge aclk) begin
    // Reload restarts the mode clock, so the old half period is void
    if (!aresetn || reload_req || state == SBML_IDLE
        || state == SBML_LEAD) begin
      gap_cnt <= 8'h00;
    end else if ($changed(config_shift_clock)) begin
      gap_cnt <= 8'h01;
    end else if (gap_cnt != 8'hff) begin
      gap_cnt <= gap_cnt + 8'h01;
    end
  end

  idle_clock_high_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !power_good |=> config_shift_clock)
    else $error("mode clock not high while power is not good");

  first_fall_a: assert property (
    @(posedge aclk) disable iff (!aresetn || !power_good || reload_req)
    (state == SBML_IDLE) |-> ##128 config_shift_clock
                             ##1 !config_shift_clock)
    else $error("mode clock first fall not 128 clocks after power good");

  half_period_a: assert property (
    @(posedge aclk) disable iff (!aresetn || !power_good)
    $changed(config_shift_clock) && $past(state) != SBML_LEAD
      && gap_cnt != 8'h00 |-> gap_cnt == 8'd128)
    else $error("mode clock half period is not 128 clocks");

  capture_rise_a: assert property (
    @(posedge aclk) disable iff (!aresetn || !power_good)
    $rose(config_shift_clock) && $past(state) == SBML_RUN
      |-> hold[$past(bit_cnt[7:0])] == $past(config_serial_in))
    else $error("bit not captured at mode clock rise");

  bit_total_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(load_done) |-> bit_cnt == `SBML_TOTAL_BITS)
    else $error("load ended with a wrong bit count");

  block_order_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    config_valid |-> config_fields.sub_block_order
                     == hold[`SBML_POS_BLK_ORDER])
    else $error("block order field decoded wrongly");

  line_words_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    config_valid && config_fields.second_cache_line_size == 2'b11
      |-> config_fields.line_words == 6'd32)
    else $error("line size 11 is not 32 words");

  float_reset_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    config_valid && config_fields.reset_output_float
      && (cold_reset_in || warm_reset_in) && load_done |=> sysif_float)
    else $error("outputs not floated during reset");

  divide_four_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sysif_clk_en && $past(config_valid)
      && config_fields.interface_clock_divider == 3'b010 && load_done
      |=> !sysif_clk_en [*3] ##1 sysif_clk_en)
    else $error("ratio 010 does not divide by four");

  pll_on_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    config_valid |-> config_fields.pll_enable == !hold[`SBML_POS_PLL_DIS])
    else $error("pll enable not the inverse of its bit");

  slew_cold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cold_reset_in && !config_fields.slew_ctl_cold_reset_enable
      && config_valid && load_done |=> !slew_ctl_active)
    else $error("slew control active during cold reset");

endmodule

`default_nettype wire

/* hdl/sbml_params.svh */
/*
  Constants of the serial boot mode loader: field positions in the
  captured word, sequence counts and register map.
  Assumes inclusion by bare name from the design files and the bench.
*/
`ifndef SBML_PARAMS_SVH
`define SBML_PARAMS_SVH

// ==========================================================
// Sequence counts, in master clocks and bits
`define SBML_HALF_PERIOD    7'd127
`define SBML_TOTAL_BITS     9'd256
`define SBML_DEFINED_BITS   65

// ==========================================================
// Field positions, first arriving bit is the field lsb
`define SBML_POS_BLK_ORDER  0
`define SBML_POS_CHECK      1
`define SBML_POS_ENDIAN     2
`define SBML_POS_DSHARED    3
`define SBML_POS_SC_ABSENT  4
`define SBML_POS_PORT       5
`define SBML_POS_SC_WIDE    7
`define SBML_POS_SC_SPLIT   8
`define SBML_POS_LINE       9
`define SBML_POS_XMIT       11
`define SBML_POS_CLKDIV     15
`define SBML_POS_TIMER      19
`define SBML_POS_POTUPD     20
`define SBML_POS_SC_TIMING  21
`define SBML_POS_PKG        45
`define SBML_POS_PDDIV      46
`define SBML_POS_DRIVE      50
`define SBML_POS_PULLDN     53
`define SBML_POS_PULLUP     57
`define SBML_POS_SLEW_COLD  61
`define SBML_POS_SLEW_EN    62
`define SBML_POS_PLL_DIS    63
`define SBML_POS_FLOAT      64

// ==========================================================
// Register map and bus answers
`define SBML_ADDR_CTRL      8'h00
`define SBML_ADDR_STATUS    8'h04
`define SBML_ADDR_RAW_LO    8'h08
`define SBML_ADDR_RAW_HI    8'h0c
`define SBML_ADDR_RAW_TOP   8'h10
`define SBML_CTRL_RELOAD    0
`define SBML_RESP_OKAY      2'b00
`define SBML_RESP_SLVERR    2'b10
`define SBML_DATA_RESET     32'h0000_0000
`define SBML_DIV_DEFAULT    4'h2

`endif

/* hdl/sbml_pkg.sv */
/*
  Types of the serial boot mode loader: sequencer states and the
  decoded configuration record.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package sbml_pkg;

  typedef enum logic [1:0] {
    SBML_IDLE,
    SBML_LEAD,
    SBML_RUN,
    SBML_DONE
  } sbml_state_type;

  typedef struct packed {
    logic       sub_block_order;
    logic       check_mode;
    logic       big_endian;
    logic       dirty_shared_enable;
    logic       second_cache_present;
    logic [1:0] sys_port_width;
    logic       sc_wide_data;
    logic       sc_split;
    logic [1:0] second_cache_line_size;
    logic [5:0] line_words;
    logic [3:0] transmit_data_pattern;
    logic [2:0] interface_clock_divider;
    logic [3:0] sysif_divide;
    logic       timer_irq_connect;
    logic       potential_update_disable;
    logic [3:0] sc_write_deassert_delay;
    logic [1:0] sc_write_assert_delay_b;
    logic [1:0] sc_write_assert_delay_a;
    logic       sc_write_recovery;
    logic [2:0] sc_disable_time;
    logic [3:0] sc_read_cycle_b;
    logic [3:0] sc_read_cycle_a;
    logic       small_package;
    logic [3:0] powerdown_clock_divider;
    logic [2:0] drive_delay;
    logic [3:0] pulldown_slew_strength;
    logic [3:0] pullup_slew_strength;
    logic       slew_ctl_cold_reset_enable;
    logic       slew_ctl_enable;
    logic       pll_enable;
    logic       reset_output_float;
  } sbml_fields_type;

endpackage

`default_nettype wire

/* hdl/sbml_cfg_if.sv */
/*
  Carrier between the loader and its field decoder.
  Assumes the loader drives raw and the decoder drives fields.
*/
`include "sbml_params.svh"
`default_nettype none

interface sbml_cfg_if;
  import sbml_pkg::*;

  logic [`SBML_DEFINED_BITS-1:0] raw;
  sbml_fields_type               fields;

  modport loader  (output raw, input fields);
  modport decoder (input raw, output fields);
endinterface

`default_nettype wire

/* hdl/sbml_decode.sv */
/*
  Field decoder: turns the defined part of the captured word into
  the configuration record.
  Assumes raw is stable whenever the record is used.
*/
`include "sbml_params.svh"
`default_nettype none

module sbml_decode
  import sbml_pkg::*;
(
  sbml_cfg_if.decoder cfg
);

  // ==========================================================
  // Fields at fixed positions
  always_comb begin
    cfg.fields = '0;
    cfg.fields.sub_block_order = cfg.raw[`SBML_POS_BLK_ORDER];
    cfg.fields.check_mode = cfg.raw[`SBML_POS_CHECK];
    cfg.fields.big_endian = cfg.raw[`SBML_POS_ENDIAN];
    cfg.fields.dirty_shared_enable = !cfg.raw[`SBML_POS_DSHARED];
    cfg.fields.second_cache_present = !cfg.raw[`SBML_POS_SC_ABSENT];
    cfg.fields.sys_port_width = cfg.raw[`SBML_POS_PORT +: 2];
    cfg.fields.sc_wide_data = cfg.raw[`SBML_POS_SC_WIDE];
    cfg.fields.sc_split = cfg.raw[`SBML_POS_SC_SPLIT];
    cfg.fields.second_cache_line_size = cfg.raw[`SBML_POS_LINE +: 2];
    // 4 << code gives 4, 8, 16, 32 words
    cfg.fields.line_words = 6'h04 << cfg.raw[`SBML_POS_LINE +: 2];
    cfg.fields.transmit_data_pattern = cfg.raw[`SBML_POS_XMIT +: 4];
    cfg.fields.interface_clock_divider = cfg.raw[`SBML_POS_CLKDIV +: 3];
    cfg.fields.sysif_divide = {1'b0, cfg.raw[`SBML_POS_CLKDIV +: 3]}
                              + 4'h2;
    cfg.fields.timer_irq_connect = !cfg.raw[`SBML_POS_TIMER];
    cfg.fields.potential_update_disable = cfg.raw[`SBML_POS_POTUPD];
    {cfg.fields.sc_read_cycle_a, cfg.fields.sc_read_cycle_b,
     cfg.fields.sc_disable_time, cfg.fields.sc_write_recovery,
     cfg.fields.sc_write_assert_delay_a, cfg.fields.sc_write_assert_delay_b,
     cfg.fields.sc_write_deassert_delay}
      = cfg.raw[`SBML_POS_SC_TIMING +: 20];
    cfg.fields.small_package = cfg.raw[`SBML_POS_PKG];
    cfg.fields.powerdown_clock_divider = cfg.raw[`SBML_POS_PDDIV +: 4];
    cfg.fields.drive_delay = cfg.raw[`SBML_POS_DRIVE +: 3];
    // Pull-down msb is stored inverted against the other slew strength bits
    cfg.fields.pulldown_slew_strength = {!cfg.raw[`SBML_POS_PULLDN + 3],
                                         cfg.raw[`SBML_POS_PULLDN +: 3]};
    cfg.fields.pullup_slew_strength = cfg.raw[`SBML_POS_PULLUP +: 4];
    cfg.fields.slew_ctl_cold_reset_enable = cfg.raw[`SBML_POS_SLEW_COLD];
    cfg.fields.slew_ctl_enable = cfg.raw[`SBML_POS_SLEW_EN];
    cfg.fields.pll_enable = !cfg.raw[`SBML_POS_PLL_DIS];
    cfg.fields.reset_output_float = cfg.raw[`SBML_POS_FLOAT];
  end

endmodule

`default_nettype wire

/* tb/sbml_prom.sv */
/*
  Serial boot PROM model: shifts out a 256-bit image, bit 0 first.
  Assumes the loader's mode clock, and power good as its counter reset.
*/
`default_nettype none

module sbml_prom (
  input  wire logic         shift_clk,
  input  wire logic         power_good,
  input  wire logic [255:0] image,
  output logic              data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int idx = 0;
  initial data_out = 1'h1;

  // ==========================================================
  // Shift out
  // Data moves on the falling edge, so it is stable at the rise
  always @(negedge shift_clk or negedge power_good) begin
    if (!power_good) begin
      idx = 0;
      data_out = ~image[0];
    end else if (idx < 256) begin
      data_out = image[idx];
      idx++;
    end else begin
      // Released after the image: invert the last value on every fall
      data_out = ~data_out;
    end
  end
endmodule

`default_nettype wire

/* tb/tb_serial_boot_mode_loader.sv */
/*
  Self-checking bench of the serial boot mode loader.
  Assumes the loader, its decoder and the PROM model are compiled first.
*/
`include "sbml_params.svh"
`default_nettype none

module tb_serial_boot_mode_loader
  import sbml_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} sbml_row_type;

  logic aclk = 0, aresetn = 0, power_good = 0, config_serial_in;
  logic cold_reset_in = 0, warm_reset_in = 0;
  logic config_shift_clock, config_valid, sysif_float;
  logic slew_ctl_active, sysif_clk_en;
  sbml_fields_type config_fields;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [255:0] image;
  sbml_row_type rows[6];
  int miscompares = 0, num_checks = 0, n;

  always #10 aclk = ~aclk;

  sbml_loader dut_u (.aclk, .aresetn, .power_good, .config_serial_in,
    .cold_reset_in, .warm_reset_in, .config_shift_clock, .config_valid,
    .config_fields, .sysif_float, .slew_ctl_active, .sysif_clk_en,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  sbml_prom prom_u (.shift_clk(config_shift_clock), .power_good, .image,
    .data_out(config_serial_in));

  // ==========================================================
  // Report
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      miscompares++;
      results();
    end
  endtask

  // ==========================================================
  // Bus master
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                        output logic [1:0] rsp);
    int k;
    logic aw, w;
    @(posedge aclk);
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (k = 0; (aw || w) && k < 100; k++) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 1'h0;
      end
    end
    tmo(k, 100);
    for (k = 0; !s_axi_bvalid && k < 100; k++) @(posedge aclk);
    tmo(k, 100);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                        output logic [1:0] rsp);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (s_axi_arready) break;
    end
    tmo(k, 100);
    s_axi_arvalid <= 1'h0;
    for (k = 0; !s_axi_rvalid && k < 100; k++) @(posedge aclk);
    tmo(k, 100);
    v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // ==========================================================
  // Sequence
  initial begin
    image = '0;
    image[0] = 1'h1;
    image[17:9] = {3'h2, 4'h0, 2'h3};
    image[40:21] = {4'h4, 4'h3, 3'h2, 1'h0, 2'h1, 2'h1, 4'h3};
    image[64:46] = {4'ha, 4'h8, 4'h1, 3'h4, 4'h3};
    rows[0] = '{`SBML_ADDR_STATUS, 32'h0001_0001, `SBML_RESP_OKAY};
    rows[1] = '{`SBML_ADDR_RAW_LO, image[31:0], `SBML_RESP_OKAY};
    rows[2] = '{`SBML_ADDR_RAW_HI, image[63:32], `SBML_RESP_OKAY};
    rows[3] = '{`SBML_ADDR_RAW_TOP, {31'h0, image[64]}, `SBML_RESP_OKAY};
    rows[4] = '{`SBML_ADDR_CTRL, 32'h0, `SBML_RESP_OKAY};
    rows[5] = '{8'h14, 32'h0, `SBML_RESP_SLVERR};
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    check({config_shift_clock, config_valid}, 2'h2);
    @(posedge aclk);
    power_good <= 1'h1;
    n = 0;
    do begin @(posedge aclk); n++; end while (config_shift_clock && n < 300);
    check(n, 130);
    n = 0;
    do begin @(posedge aclk); n++; end while (!config_shift_clock && n < 300);
    check(n, 128);
    for (n = 0; !config_valid && n < 70000; n++) @(posedge aclk);
    tmo(n, 70000);
    check({config_fields.sub_block_order, config_fields.dirty_shared_enable,
      config_fields.second_cache_present, config_fields.timer_irq_connect,
      config_fields.pll_enable, config_fields.reset_output_float},
      6'h3f);
    check({config_fields.second_cache_line_size, config_fields.line_words},
      {2'h3, 6'h20});
    check({config_fields.transmit_data_pattern,
      config_fields.interface_clock_divider, config_fields.sysif_divide},
      {4'h0, 3'h2, 4'h4});
    check({config_fields.sc_read_cycle_a, config_fields.sc_read_cycle_b,
      config_fields.sc_disable_time, config_fields.sc_write_recovery,
      config_fields.sc_write_assert_delay_a,
      config_fields.sc_write_assert_delay_b,
      config_fields.sc_write_deassert_delay}, image[40:21]);
    check({config_fields.powerdown_clock_divider,
      config_fields.pulldown_slew_strength,
      config_fields.pullup_slew_strength}, 12'h398);
    for (int i = 0; i < 6; i++) begin
      axi_rd(rows[i].a, d, r);
      check({r, d}, {rows[i].r, rows[i].d});
    end
    n = 0;
    repeat (40) begin @(posedge aclk); n += sysif_clk_en; end
    check(n, 10);
    check(slew_ctl_active, 1'h1);
    cold_reset_in <= 1'h1;
    repeat (3) @(posedge aclk);
    check({sysif_float, slew_ctl_active}, 2'h2);
    cold_reset_in <= 1'h0;
    warm_reset_in <= 1'h1;
    repeat (3) @(posedge aclk);
    check({sysif_float, slew_ctl_active}, 2'h3);
    warm_reset_in <= 1'h0;
    repeat (3) @(posedge aclk);
    check(sysif_float, 1'h0);
    axi_wr(`SBML_ADDR_STATUS, 32'h1, r);
    check(r, `SBML_RESP_SLVERR);
    axi_wr(`SBML_ADDR_CTRL, 32'h1, r);
    check(r, `SBML_RESP_OKAY);
    axi_rd(`SBML_ADDR_STATUS, d, r);
    check(d, 32'h0000_0000);
    // Loading flag rises only after the 128-clock lead-in
    repeat (130) @(posedge aclk);
    axi_rd(`SBML_ADDR_STATUS, d, r);
    check(d, 32'h0000_0002);
    results();
  end
endmodule

`default_nettype wire
